// ===== include/poll_pkg.sv
// Constants, types and timing for the poll step sequencer.
// Assumes a 250 MHz core clock.
package poll_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned STEP_MAX = 34;
   localparam int unsigned IDX_W = 6;
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_COILS = 8'h01;
   localparam logic [7:0] FC_DISC = 8'h02;
   localparam logic [7:0] FC_HOLD = 8'h03;
   localparam logic [7:0] FC_INPUT = 8'h04;
   localparam logic [7:0] FC_WCOIL = 8'h05;
   localparam logic [7:0] CNT_BIT_MAX = 8'h01;
   localparam logic [7:0] CNT_STD_MAX = 8'h19;
   localparam logic [7:0] CNT_ENRON_MAX = 8'h0C;
   localparam logic [15:0] OFS_ZERO = 16'h0000;
   localparam logic [15:0] OFS_ONE = 16'h0001;
   localparam int unsigned BAUD = 9600;
   localparam int unsigned TIMEOUT_MS = 1000;
   localparam int unsigned PAUSE_MS = 100;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned PAUSE_CYC = PAUSE_MS * 1000 * CLK_MHZ;
   localparam int unsigned BAUD_DIV = (CLK_MHZ * 1000000) / BAUD;
   localparam int unsigned TMR_W = 32;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_ISSUE, ST_WAIT, ST_PAUSE} seq_state_t;
endpackage

// ===== logic/poll_sequencer.sv
// Poll step sequencer: walks the step table on each check-in taken while idle (ignored during a walk) and
// issues one request per valid step. Assumes a separate frame engine
// performs the serial transfer and reports done/error.
//
// Summary of operation
// - Check-in polls sensor using stored step list
// - Table of 34 steps: code, address, count
// - Coil/discrete reads limited to one coil
// - Only codes 0x03, 0x04, 0x05 also accepted
// - Subtract addressing offset from entered address
// - Count limit 25, Enron 12, else reject
// - Defaults 9600 8N1, timeout 1000ms, pause 100ms
`timescale 1ns/1ps
module poll_sequencer #(
   parameter int unsigned TIMEOUT_CYCLES = poll_pkg::TIMEOUT_CYC,
   parameter int unsigned PAUSE_CYCLES = poll_pkg::PAUSE_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic CHECKIN_I,
   input wire logic ONE_BASED_I,
   input wire logic ENRON_I,
   input wire logic [7:0] SLAVE_ID_I,
   input wire logic WR_EN_I,
   input wire logic [poll_pkg::IDX_W-1:0] WR_IDX_I,
   input wire logic [7:0] WR_FUNC_I,
   input wire logic [15:0] WR_ADDR_I,
   input wire logic [7:0] WR_COUNT_I,
   input wire logic REQ_READY_I,
   input wire logic RSP_DONE_I,
   input wire logic RSP_ERR_I,
   output logic REQ_VALID_O,
   output logic [7:0] REQ_SLAVE_O,
   output logic [7:0] REQ_FUNC_O,
   output logic [15:0] REQ_ADDR_O,
   output logic [7:0] REQ_COUNT_O,
   output logic [poll_pkg::IDX_W-1:0] REQ_IDX_O,
   output logic [poll_pkg::STEP_MAX-1:0] PASS_O,
   output logic [poll_pkg::STEP_MAX-1:0] FAIL_O,
   output logic BUSY_O,
   output logic DONE_O
);
   import poll_pkg::*;

   typedef struct packed {
      seq_state_t state;
      logic [IDX_W-1:0] idx;
      logic [TMR_W-1:0] tmr;
      logic req_valid;
      logic [7:0] slave;
      logic [7:0] func;
      logic [15:0] addr;
      logic [7:0] count;
      logic [IDX_W-1:0] req_idx;
      logic [STEP_MAX-1:0] pass;
      logic [STEP_MAX-1:0] fail;
      logic busy;
      logic done;
   } seq_t;
   seq_t s_reg, s_next;

   // Step table storage
   logic [7:0] func_mem [STEP_MAX];
   logic [15:0] addr_mem [STEP_MAX];
   logic [7:0] count_mem [STEP_MAX];
   logic [IDX_W-1:0] last_idx;
   logic [7:0] cur_func;
   logic [15:0] cur_addr;
   logic [7:0] cur_count;
   logic cur_empty;
   logic cur_valid;
   logic any_left;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(STEP_MAX - 1);
   localparam logic [TMR_W-1:0] TMO_T = TMR_W'(TIMEOUT_CYCLES);
   localparam logic [TMR_W-1:0] PAUSE_T = TMR_W'(PAUSE_CYCLES);

   // Table position after the current one
   function automatic logic [IDX_W-1:0] step_after(input logic [IDX_W-1:0] idx);
      return idx + IDX_W'(1);
   endfunction

   // Count-down timer shared by the timeout and the pause
   function automatic logic [TMR_W-1:0] tmr_dec(input logic [TMR_W-1:0] tmr);
      return tmr - TMR_W'(1);
   endfunction

   function automatic logic tmr_expired(input logic [TMR_W-1:0] tmr);
      return tmr <= TMR_W'(1);
   endfunction

   // Leaves the walk: idle again, busy low and a one-cycle done pulse
   function automatic seq_t walk_end(input seq_t s);
      seq_t r;
      r = s;
      r.state = ST_IDLE;
      r.busy = 1'b0;
      r.done = 1'b1;
      return r;
   endfunction

   // Writes are refused while a walk reads the table
   always_ff @(posedge CORE_CLK_I) begin
      if (WR_EN_I && (WR_IDX_I <= IDX_LAST) && !s_reg.busy) begin
         func_mem[WR_IDX_I] <= WR_FUNC_I;
         addr_mem[WR_IDX_I] <= WR_ADDR_I;
         count_mem[WR_IDX_I] <= WR_COUNT_I;
      end
   end

   // Highest populated entry ends the walk
   always_comb begin
      last_idx = '0;
      any_left = 1'b0;
      for (int i = 0; i < STEP_MAX; i++) begin
         if (func_mem[i] != FC_NONE) begin
            last_idx = IDX_W'(i);
            any_left = 1'b1;
         end
      end
   end

   assign cur_func = func_mem[s_reg.idx];
   assign cur_addr = addr_mem[s_reg.idx];
   assign cur_count = count_mem[s_reg.idx];
   step_check u_check (
      .func_i(cur_func),
      .count_i(cur_count),
      .enron_i(ENRON_I),
      .empty_o(cur_empty),
      .valid_o(cur_valid)
   );

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.state)
         ST_IDLE: begin
            if (CHECKIN_I) begin
               s_next.idx = '0;
               s_next.pass = '0;
               s_next.fail = '0;
               s_next.busy = any_left;
               s_next.done = !any_left;
               s_next.state = any_left ? ST_FETCH : ST_IDLE;
            end
         end
         ST_FETCH: begin
            if (cur_empty) begin
               s_next.idx = step_after(s_reg.idx);
            end else if (!cur_valid) begin
               s_next.fail[s_reg.idx] = 1'b1;
               s_next.idx = step_after(s_reg.idx);
            end else begin
               s_next.req_valid = 1'b1;
               s_next.slave = SLAVE_ID_I;
               s_next.func = cur_func;
               s_next.addr = cur_addr - (ONE_BASED_I ? OFS_ONE : OFS_ZERO);
               s_next.count = cur_count;
               s_next.req_idx = s_reg.idx;
               s_next.state = ST_ISSUE;
            end
            if ((cur_empty || !cur_valid) && s_reg.idx == last_idx) begin
               s_next = walk_end(s_next);
            end
         end
         ST_ISSUE: begin
            // Request stands until the frame engine takes it
            if (REQ_READY_I) begin
               s_next.req_valid = 1'b0;
               s_next.tmr = TMO_T;
               s_next.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            s_next.tmr = tmr_dec(s_reg.tmr);
            if (RSP_DONE_I) begin
               s_next.pass[s_reg.req_idx] = !RSP_ERR_I;
               s_next.fail[s_reg.req_idx] = RSP_ERR_I;
               s_next.tmr = PAUSE_T;
               s_next.state = ST_PAUSE;
            end else if (tmr_expired(s_reg.tmr)) begin
               s_next.fail[s_reg.req_idx] = 1'b1;
               s_next.tmr = PAUSE_T;
               s_next.state = ST_PAUSE;
            end
         end
         ST_PAUSE: begin
            s_next.tmr = tmr_dec(s_reg.tmr);
            if (tmr_expired(s_reg.tmr)) begin
               if (s_reg.idx == last_idx) begin
                  s_next = walk_end(s_next);
               end else begin
                  s_next.idx = step_after(s_reg.idx);
                  s_next.state = ST_FETCH;
               end
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_reg <= '{state: ST_IDLE, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign REQ_VALID_O = s_reg.req_valid;
   assign REQ_SLAVE_O = s_reg.slave;
   assign REQ_FUNC_O = s_reg.func;
   assign REQ_ADDR_O = s_reg.addr;
   assign REQ_COUNT_O = s_reg.count;
   assign REQ_IDX_O = s_reg.req_idx;
   assign PASS_O = s_reg.pass;
   assign FAIL_O = s_reg.fail;
   assign BUSY_O = s_reg.busy;
   assign DONE_O = s_reg.done;
endmodule // poll_sequencer

// ===== logic/step_check.sv
// Step validator: checks function code and count limit of one step.
// Purely combinational; fed by the sequencer's table read.
`timescale 1ns/1ps
module step_check (
   input wire logic [7:0] func_i,
   input wire logic [7:0] count_i,
   input wire logic enron_i,
   output logic empty_o,
   output logic valid_o
);
   import poll_pkg::*;
   logic [7:0] limit;
   logic fc_ok;
   always_comb begin
      empty_o = (func_i == FC_NONE);
      fc_ok = 1'b1;
      limit = enron_i ? CNT_ENRON_MAX : CNT_STD_MAX;
      unique case (func_i)
         FC_COILS, FC_DISC: limit = CNT_BIT_MAX;
         FC_HOLD, FC_INPUT, FC_WCOIL: ;
         default: fc_ok = 1'b0;
      endcase
      valid_o = fc_ok && (count_i != 8'h00) && (count_i <= limit);
   end
endmodule // step_check

// ===== testbench/modbus_poll_step_sequencer_tb_top.sv
// Bench: random step tables with corner entries, both limits and address modes,
// passing, failing and silent sensors. Needs sensor_model.
`timescale 1ns/1ps
module modbus_poll_step_sequencer_tb_top;
   import poll_pkg::*;
   logic clk = 0, rst_n = 0, chk_in = 0, one_b = 0, enron = 0, wr_en = 0;
   logic slow = 0, fail = 0, mute = 0, rdy, dn, er, vld, busy, done;
   logic [7:0] sid = 8'h00, wf = 8'h00, wc = 8'h00, lim = 8'h00, rslv, rfn, rcn;
   logic [IDX_W-1:0] wi = '0, ridx;
   logic [15:0] wa = 16'h0000, radr;
   logic [STEP_MAX-1:0] pass_v, fail_v, ep, ef;
   logic [7:0] tf [STEP_MAX], tc [STEP_MAX];
   logic [15:0] ta [STEP_MAX];
   int fails = 0, n_checks = 0, t, q [$];
   poll_sequencer #(.TIMEOUT_CYCLES(50), .PAUSE_CYCLES(10)) poll_sequencer_i (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .CHECKIN_I(chk_in), .ONE_BASED_I(one_b),
      .ENRON_I(enron), .SLAVE_ID_I(sid), .WR_EN_I(wr_en), .WR_IDX_I(wi), .WR_FUNC_I(wf),
      .WR_ADDR_I(wa), .WR_COUNT_I(wc), .REQ_READY_I(rdy), .RSP_DONE_I(dn), .RSP_ERR_I(er),
      .REQ_VALID_O(vld), .REQ_SLAVE_O(rslv), .REQ_FUNC_O(rfn), .REQ_ADDR_O(radr),
      .REQ_COUNT_O(rcn), .REQ_IDX_O(ridx), .PASS_O(pass_v), .FAIL_O(fail_v),
      .BUSY_O(busy), .DONE_O(done));
   sensor_model sensor_model_i (.clk_i(clk), .valid_i(vld), .id_i(sid), .slave_i(rslv),
      .slow_i(slow), .fail_i(fail), .mute_i(mute), .ready_o(rdy), .done_o(dn), .err_o(er));
   initial forever #2 clk = ~clk;
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic ok_step(logic [7:0] f, logic [7:0] c, logic e);
      return f >= FC_COILS && f <= FC_WCOIL && c != 8'h00 &&
         c <= (f <= FC_DISC ? CNT_BIT_MAX : e ? CNT_ENRON_MAX : CNT_STD_MAX);
   endfunction
   task automatic wr(input int j);
      @(posedge clk);
      #1 {wr_en, wi, wf, wa, wc} = {1'b1, 6'(j), tf[j], ta[j], tc[j]};
      @(posedge clk);
      #1 wr_en = 1'b0;
   endtask
   always @(negedge clk) if (vld && rdy) begin
      int i;
      i = q.size() > 0 ? q.pop_front() : 99;
      chk(ridx === i[5:0] && rfn === tf[i] && rcn === tc[i], "step fields");
      chk(radr === ta[i] - (one_b ? OFS_ONE : OFS_ZERO), "address offset");
      chk(rslv === sid, "slave id");
   end
   initial begin
      #160000;
      fails++;
      close_out();
   end
   initial begin
      void'($urandom(32'h8db3));
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      for (int k = 0; k < 6; k++) begin
         {enron, one_b, slow, fail, mute} = {k[0], k[1], k[0], k == 4, k == 5};
         sid = 8'($urandom);
         lim = enron ? CNT_ENRON_MAX : CNT_STD_MAX;
         ep = '0;
         ef = '0;
         for (int j = 0; j < STEP_MAX; j++) begin
            tf[j] = ($urandom % 3 == 0) ? FC_NONE : 8'($urandom % 7);
            tc[j] = 8'($urandom % 28);
            ta[j] = 16'($urandom);
            if (j == 0) {tf[j], tc[j], ta[j]} = {FC_HOLD, lim, 16'h0000};
            if (j == 1) {tf[j], tc[j]} = {FC_INPUT, lim + 8'h01};
            if (j == 2) {tf[j], tc[j]} = {FC_HOLD, 8'h02};
            if (j == 33) {tf[j], tc[j]} = {8'(1 + k % 2), 8'(1 + k % 2)};
            wr(j);
            if (ok_step(tf[j], tc[j], enron)) begin
               q.push_back(j);
               ep[j] = !fail && !mute;
               ef[j] = fail || mute;
            end else if (tf[j] != FC_NONE) ef[j] = 1'b1;
         end
         chk_in = 1'b1;
         @(posedge clk);
         #1 chk_in = 1'b0;
         t = 0;
         while (done !== 1'b1 && t < 5000) begin
            @(posedge clk);
            #1 t++;
            chk_in = (t == 20);
         end
         chk(t < 5000 && busy === 1'b0, "walk end");
         chk(pass_v === ep && fail_v === ef && q.size() == 0, "step status");
      end
      close_out();
   end
endmodule // modbus_poll_step_sequencer_tb_top

// ===== testbench/poll_sequencer_props.sv
// Checker for the request handshake and step limits of the poll sequencer.
// Sees only the top ports; bound to every poll_sequencer below.
`timescale 1ns/1ps
module poll_sequencer_props
   import poll_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = 50,
   parameter int unsigned PAUSE_CYCLES = 10
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic CHECKIN_I,
   input wire logic ENRON_I,
   input wire logic REQ_READY_I,
   input wire logic REQ_VALID_O,
   input wire logic [7:0] REQ_FUNC_O,
   input wire logic [15:0] REQ_ADDR_O,
   input wire logic [7:0] REQ_COUNT_O,
   input wire logic [poll_pkg::IDX_W-1:0] REQ_IDX_O,
   input wire logic BUSY_O,
   input wire logic DONE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   walk_start_a: assert property (CHECKIN_I && !BUSY_O |=> BUSY_O || DONE_O)
      else $error("check-in did not start a walk");
   req_hold_a: assert property (REQ_VALID_O && !REQ_READY_I |=> REQ_VALID_O
      && $stable(REQ_ADDR_O) && $stable(REQ_IDX_O)) else $error("request dropped early");
   one_at_time_a: assert property (REQ_VALID_O && REQ_READY_I |=> !REQ_VALID_O [*3])
      else $error("next request without wait");
   func_legal_a: assert property (REQ_VALID_O |-> REQ_FUNC_O inside {[FC_COILS:FC_WCOIL]})
      else $error("illegal function issued");
   coil_single_a: assert property (REQ_VALID_O && REQ_FUNC_O <= FC_DISC
      |-> REQ_COUNT_O == CNT_BIT_MAX) else $error("bit read count not one");
   count_limit_a: assert property (REQ_VALID_O |-> REQ_COUNT_O != 8'h00
      && REQ_COUNT_O <= (ENRON_I ? CNT_ENRON_MAX : CNT_STD_MAX)) else $error("count over limit");
   idx_range_a: assert property (REQ_VALID_O |-> REQ_IDX_O < STEP_MAX)
      else $error("step index out of table");
   done_pulse_a: assert property (DONE_O |-> !BUSY_O ##1 !DONE_O)
      else $error("done not a lone pulse");
endmodule // poll_sequencer_props

bind poll_sequencer poll_sequencer_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
   .PAUSE_CYCLES(PAUSE_CYCLES)) props_i (.CORE_CLK_I, .RST_N_I, .CHECKIN_I, .ENRON_I,
   .REQ_READY_I, .REQ_VALID_O, .REQ_FUNC_O, .REQ_ADDR_O, .REQ_COUNT_O, .REQ_IDX_O,
   .BUSY_O, .DONE_O);

// ===== testbench/sensor_model.sv
// Sensor behind the frame engine: takes a request, answers after a delay.
// Slow delays acceptance; mute never answers, so the sequencer times out.
// Answers only requests that carry its own slave id.
`timescale 1ns/1ps
module sensor_model (
   input wire logic clk_i,
   input wire logic valid_i,
   input wire logic [7:0] id_i,
   input wire logic [7:0] slave_i,
   input wire logic slow_i,
   input wire logic fail_i,
   input wire logic mute_i,
   output logic ready_o = 1'b0,
   output logic done_o = 1'b0,
   output logic err_o = 1'b0
);
   logic hit = 1'b0;
   initial forever begin
      @(posedge clk_i);
      #1;
      if (valid_i) begin
         hit = (slave_i == id_i) && !mute_i;
         repeat (slow_i ? 4 : 0) begin
            @(posedge clk_i);
            #1;
         end
         ready_o = 1'b1;
         @(posedge clk_i);
         #1 ready_o = 1'b0;
         if (hit) begin
            repeat (2) @(posedge clk_i);
            #1 done_o = 1'b1;
            err_o = fail_i;
            @(posedge clk_i);
            #1 done_o = 1'b0;
            err_o = ~err_o;
         end
      end
   end
endmodule // sensor_model
